/* File: counter_mode_sequencer.sv */
`timescale 1ns/1ns
// How it works
// - Level-gated strobe counts only while armed and gate active.
// - Level-gated strobe pauses on gate low, resumes from held count.
// - Level-gated strobe loads load value and disarms at terminal count.
// - Hardware strobe starts only after arming plus a gate edge.
// - Started hardware strobe ignores gate; needs new arm and edge after.
// - Ungated rate generator reloads load value forever until disarm.
// - Level-gated rate generator repeats while armed, counting when gate high.
// - Non-retriggerable one-shot: each gate edge on idle armed counter runs once.
// - Non-retriggerable one-shot ignores gate edges while counting.
// - Delayed pulse: load count, hold reload, hold count, disarm, load reload.
// - Toggle output gives load-count delay then hold-count pulse.
// - Gated delayed pulse counts only with gate high, disarms after second end.
// - Triggered delayed pulse starts on first edge, then ignores gate.
// - Variable duty alternates hold and load reloads until disarmed.
// - Toggle output stays one state for load count, other for hold.
// - Level-gated variable duty alternates only while gate asserted.
// - Triggered delayed one-shot runs one load-hold cycle per idle edge.
// - Level retrigger strobe starts on gate high, halts on low, disarms at end.
// - Gate return on halted counter saves count, reloads load on next edge.
// - Edge retrigger strobe: gate edge reloads load on next source edge.
// - Synchronized rate generator: gate edge reloads, resumes second source edge.
// - Retriggerable one-shot: early gate edge saves count and reloads load.
// - Repeat bit selects disarm at terminal count or continue reloading.
// - Reload bit clear uses load register; set alternates with hold unless the special gate bit is set.
// - Counting starts on first source edge after arm or gate start; a pending retrigger reload or sync wait takes the first edge.
module counter_mode_sequencer
import counter_mode_pkg::*;
#(
	parameter int W = CNT_W
)
(
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire counter_mode_pkg::mode_cfg_t modeCfg,
	input  wire counter_mode_pkg::host_cmd_t hostCmd,
	input  wire logic [W-1:0]           loadReg,
	input  wire logic [W-1:0]           holdRegIn,
	input  wire logic                   holdRegWrite,
	input  wire logic                   countSource,
	input  wire logic                   gateIn,
	output logic [W-1:0]                count,
	output logic [W-1:0]                holdReg,
	output logic                        armed,
	output logic                        terminalCount,
	output logic                        toggleOut
);
	import counter_mode_pkg::*;

	logic       srcEdge;
	logic       gateLevelRaw;
	logic       gateRise;
	logic       gateFall;
	logic       gateLevel;
	logic       gateEdge;
	logic       levelGated;
	logic       edgeGated;
	logic       ungated;
	logic [W-1:0] cnt;
	logic       atOne;
	logic       cntLoad;
	logic [W-1:0] cntLoadValue;
	logic       cntStep;
	logic       tcEvent;
	logic       secondPhase_r;
	logic       secondPhase_nxt;
	logic       armed_r;
	logic       armed_nxt;
	logic       retrigPend_r;
	logic       retrigPend_nxt;
	logic       saveHold;
	logic [1:0] syncWait_r;
	logic [1:0] syncWait_nxt;
	logic       toggle_r;
	logic       tc_r;
	logic [W-1:0] hold_r;
	logic       advance;
	logic       lastPhase;
	logic       twoPhase;
	seq_state_t state_r;
	seq_state_t state_nxt;

	// Both external inputs cross into clk_sys here
	input_sync u_srcSync
	(
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.asyncIn (countSource),
		.level   (),
		.rise    (srcEdge),
		.fall    ()
	);

	input_sync u_gateSync
	(
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.asyncIn (gateIn),
		.level   (gateLevelRaw),
		.rise    (gateRise),
		.fall    (gateFall)
	);

	down_counter #(.W(W)) u_counter
	(
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.load      (cntLoad),
		.loadValue (cntLoadValue),
		.step      (cntStep),
		.count     (cnt),
		.atOne     (atOne)
	);

	assign ungated    = (modeCfg.gatingControlField == GATE_NONE);
	assign edgeGated  = (modeCfg.gatingControlField == GATE_EDGE_RISE) ||
	                    (modeCfg.gatingControlField == GATE_EDGE_FALL);
	assign levelGated = !ungated && !edgeGated;
	// Level low selects active-low gating; other level codes use high
	assign gateLevel  = (modeCfg.gatingControlField == GATE_LVL_LO) ? ~gateLevelRaw
	                                                                : gateLevelRaw;
	assign gateEdge   = (modeCfg.gatingControlField == GATE_EDGE_FALL) ? gateFall
	                  : (modeCfg.gatingControlField == GATE_LVL_LO) ? gateFall
	                  : gateRise;
	// Alternating load/hold only with reload bit set and no special gate
	assign twoPhase   = modeCfg.reloadSourceBit && !modeCfg.specialGateBit;
	assign lastPhase  = !twoPhase || secondPhase_r;

	// Source edges advance the count only in the run state with gate allowed
	always_comb
	begin
		advance = 1'b0;
		if (state_r == ST_RUN && srcEdge && armed_r)
		begin
			if (levelGated && !(modeCfg.specialGateBit && edgeGated))
				advance = gateLevel;
			else
				advance = 1'b1;
		end
		// Sync wait blocks only the first source edge; the second one counts
		if (modeCfg.specialGateBit && (retrigPend_r || syncWait_r > 2'h1))
			advance = 1'b0;
	end

	assign tcEvent = advance && atOne;

	// Reload source and counter load
	always_comb
	begin
		cntLoad      = 1'b0;
		cntLoadValue = loadReg;
		if (hostCmd.arm && state_r == ST_IDLE)
			cntLoad = 1'b1;
		else if (retrigPend_r && srcEdge)
			cntLoad = 1'b1;
		else if (modeCfg.specialGateBit && gateEdge && armed_r && state_r == ST_RUN
		         && !retrigPend_r && modeCfg.repeatSelectBit && levelGated)
			cntLoad = 1'b1;
		else if (modeCfg.specialGateBit && edgeGated && modeCfg.repeatSelectBit
		         && gateEdge && state_r == ST_RUN && !modeCfg.reloadSourceBit
		         && !tcEvent)
			cntLoad = 1'b1;
		else if (tcEvent)
		begin
			cntLoad = 1'b1;
			if (twoPhase && !secondPhase_r)
				cntLoadValue = hold_r;
			else
				cntLoadValue = loadReg;
		end
	end

	assign cntStep = advance && !tcEvent;

	// Count save into hold on retrigger
	assign saveHold = modeCfg.specialGateBit && armed_r && gateEdge &&
	                  (state_r == ST_RUN || state_r == ST_HALT) && !tcEvent &&
	                  (!modeCfg.repeatSelectBit || edgeGated);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			hold_r <= COUNT_RESET;
		else if (saveHold)
			hold_r <= cnt;
		else if (holdRegWrite)
			hold_r <= holdRegIn;
	end

	// Sequencer
	always_comb
	begin
		state_nxt       = state_r;
		armed_nxt       = armed_r;
		secondPhase_nxt = secondPhase_r;
		retrigPend_nxt  = retrigPend_r && !srcEdge;
		syncWait_nxt    = syncWait_r;
		if (syncWait_r != 2'h0 && srcEdge)
			syncWait_nxt = syncWait_r - 2'h1;
		unique case (state_r)
			ST_IDLE:
			begin
				secondPhase_nxt = 1'b0;
				if (hostCmd.arm)
				begin
					armed_nxt = 1'b1;
					// Software start on next source edge; edge gating waits in ST_WAIT for a gate edge
					state_nxt = edgeGated ? ST_WAIT : ST_RUN;
				end
			end
			ST_WAIT:
			begin
				if (gateEdge)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (tcEvent)
				begin
					secondPhase_nxt = twoPhase ? !secondPhase_r : 1'b0;
					if (lastPhase && !modeCfg.repeatSelectBit)
					begin
						if (edgeGated && !modeCfg.specialGateBit)
						begin
							state_nxt = ST_IDLE;
							armed_nxt = 1'b0;
						end
						else
						begin
							state_nxt = ST_IDLE;
							armed_nxt = 1'b0;
						end
					end
					else if (lastPhase && edgeGated)
						state_nxt = ST_WAIT;
				end
				else if (modeCfg.specialGateBit && levelGated && !gateLevel
				         && !modeCfg.repeatSelectBit)
					state_nxt = ST_HALT;
				else if (modeCfg.specialGateBit && edgeGated && gateEdge
				         && !modeCfg.repeatSelectBit && modeCfg.reloadSourceBit)
					retrigPend_nxt = 1'b1;
				else if (modeCfg.specialGateBit && edgeGated && gateEdge
				         && !modeCfg.repeatSelectBit && !modeCfg.reloadSourceBit)
					retrigPend_nxt = 1'b1;
				else if (modeCfg.specialGateBit && levelGated && gateEdge
				         && modeCfg.repeatSelectBit)
					syncWait_nxt = SYNC_WAIT_EDGES;
			end
			ST_HALT:
			begin
				if (gateLevel)
				begin
					state_nxt      = ST_RUN;
					retrigPend_nxt = 1'b1;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
		if (hostCmd.disarm)
		begin
			armed_nxt = 1'b0;
			state_nxt = ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r       <= ST_IDLE;
			armed_r       <= 1'b0;
			secondPhase_r <= 1'b0;
			retrigPend_r  <= 1'b0;
			syncWait_r    <= 2'h0;
		end
		else
		begin
			state_r       <= state_nxt;
			armed_r       <= armed_nxt;
			secondPhase_r <= secondPhase_nxt;
			retrigPend_r  <= retrigPend_nxt;
			syncWait_r    <= syncWait_nxt;
		end
	end

	// Toggle flips at each terminal count; load then hold phases
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			toggle_r <= 1'b0;
			tc_r     <= 1'b0;
		end
		else
		begin
			tc_r <= tcEvent;
			if (tcEvent)
				toggle_r <= ~toggle_r;
			else if (hostCmd.arm && state_r == ST_IDLE)
				toggle_r <= 1'b0;
		end
	end

	assign count         = cnt;
	assign holdReg       = hold_r;
	assign armed         = armed_r;
	assign terminalCount = tc_r;
	assign toggleOut     = toggle_r;

	a_idle_no_count: assert property (@(posedge clk_sys) disable iff (!nrst)
		!armed_r |-> !cntStep)
		else $error("counter stepped while disarmed");

	a_level_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
		(levelGated && !modeCfg.specialGateBit && !gateLevel) |-> !cntStep)
		else $error("counter stepped with gate inactive");

	a_wait_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		(state_r == ST_WAIT && !gateEdge && !hostCmd.disarm) |=> state_r == ST_WAIT)
		else $error("left wait without gate edge");

	a_once_disarm: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tcEvent && lastPhase && !modeCfg.repeatSelectBit) |=> !armed_r)
		else $error("single count did not disarm");

	a_repeat_armed: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tcEvent && modeCfg.repeatSelectBit && !hostCmd.disarm) |=> armed_r)
		else $error("repeat mode disarmed at end");

	a_disarm_cmd: assert property (@(posedge clk_sys) disable iff (!nrst)
		hostCmd.disarm |=> (!armed_r && state_r == ST_IDLE))
		else $error("disarm command ignored");

	a_toggle_tc: assert property (@(posedge clk_sys) disable iff (!nrst)
		tcEvent |=> (toggle_r != $past(toggle_r) && tc_r))
		else $error("toggle did not flip at terminal count");

	a_hold_reload: assert property (@(posedge clk_sys) disable iff (!nrst)
		(tcEvent && twoPhase && !secondPhase_r) |=> cnt == $past(hold_r))
		else $error("first phase did not reload hold");

	a_save_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		saveHold |=> hold_r == $past(cnt))
		else $error("retrigger did not save count");
endmodule : counter_mode_sequencer

/* File: counter_mode_pkg.sv */
package counter_mode_pkg;

	localparam int CNT_W = 16;

	// Gating field codes
	localparam logic [2:0] GATE_NONE      = 3'h0;
	localparam logic [2:0] GATE_LVL_HI_N1 = 3'h1;
	localparam logic [2:0] GATE_LVL_HI_P1 = 3'h2;
	localparam logic [2:0] GATE_LVL_HI_M1 = 3'h3;
	localparam logic [2:0] GATE_LVL_HI    = 3'h4;
	localparam logic [2:0] GATE_LVL_LO    = 3'h5;
	localparam logic [2:0] GATE_EDGE_RISE = 3'h6;
	localparam logic [2:0] GATE_EDGE_FALL = 3'h7;

	localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] COUNT_ONE   = 16'h0001;

	// Q mode sync wait spans this many source edges after a gate edge; the last of them counts
	localparam logic [1:0] SYNC_WAIT_EDGES = 2'h2;

	typedef struct packed {
		logic [2:0] gatingControlField;
		logic       specialGateBit;
		logic       reloadSourceBit;
		logic       repeatSelectBit;
	} mode_cfg_t;

	typedef struct packed {
		logic arm;
		logic disarm;
	} host_cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_WAIT  = 4'b0010,
		ST_RUN   = 4'b0100,
		ST_HALT  = 4'b1000
	} seq_state_t;

endpackage : counter_mode_pkg

/* File: input_sync.sv */
`timescale 1ns/1ns
module input_sync
(
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic asyncIn,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic stage1_r;
	logic stage2_r;
	logic prev_r;

	// Stage 1 feeds only stage 2
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1_r <= 1'b0;
			stage2_r <= 1'b0;
			prev_r   <= 1'b0;
		end
		else
		begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
			prev_r   <= stage2_r;
		end
	end

	assign level = stage2_r;
	assign rise  = stage2_r & ~prev_r;
	assign fall  = ~stage2_r & prev_r;
endmodule : input_sync

/* File: down_counter.sv */
`timescale 1ns/1ns
module down_counter
#(
	parameter int W = 16
)
(
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic         load,
	input  wire logic [W-1:0] loadValue,
	input  wire logic         step,
	output logic [W-1:0]      count,
	output logic              atOne
);
	logic [W-1:0] count_r;

	// Load wins over step so a reload on a source edge is exact
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			count_r <= '0;
		else if (load)
			count_r <= loadValue;
		else if (step)
			count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
	end

	assign count = count_r;
	assign atOne = (count_r == {{(W-1){1'b0}}, 1'b1}) || (count_r == '0);
endmodule : down_counter

/* File: source_model.sv */
`timescale 1ns/1ns
module source_model
(
	input  wire logic clk_sys,
	input  wire logic edgeReq,
	input  wire logic slow,
	output logic      countSource,
	output logic      busy
);
	logic [3:0] phase = 4'h0;

	// Wide high and low phases so the two-flop sync sees each level
	always @(posedge clk_sys)
	begin
		if (edgeReq && !busy)
			phase <= (slow ? 4'hC : 4'h6);
		else if (busy)
			phase <= phase - 4'h1;
	end

	// Source stands low between pulses
	assign busy        = (phase != 4'h0);
	assign countSource = busy && (phase > (slow ? 4'h6 : 4'h3));
endmodule : source_model

/* File: counter_mode_sequencer_tb.sv */
`timescale 1ns/1ns
module counter_mode_sequencer_tb;
	import counter_mode_pkg::*;
	logic             clk_sys      = 1'b0;
	logic             nrst         = 1'b0;
	mode_cfg_t        modeCfg      = '0;
	host_cmd_t        hostCmd      = '0;
	logic [CNT_W-1:0] loadReg      = '0;
	logic [CNT_W-1:0] holdRegIn    = '0;
	logic             holdRegWrite = 1'b0;
	logic             gateIn       = 1'b0;
	logic             edgeReq      = 1'b0;
	logic             slow         = 1'b0;
	logic             countSource;
	logic             busy;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] holdReg;
	logic             armed;
	logic             terminalCount;
	logic             toggleOut;
	int               err_total    = 0;
	int               cmp_count    = 0;
	int               tcTotal      = 0;
	int               cycles       = 0;
	int               n;
	logic [31:0]      seed         = 32'h25902E7E;
	logic [CNT_W-1:0] lv;
	logic [CNT_W-1:0] hv;

	always #20 clk_sys = ~clk_sys;

	counter_mode_sequencer dut_u
	(
		.clk_sys       (clk_sys),
		.nrst          (nrst),
		.modeCfg       (modeCfg),
		.hostCmd       (hostCmd),
		.loadReg       (loadReg),
		.holdRegIn     (holdRegIn),
		.holdRegWrite  (holdRegWrite),
		.countSource   (countSource),
		.gateIn        (gateIn),
		.count         (count),
		.holdReg       (holdReg),
		.armed         (armed),
		.terminalCount (terminalCount),
		.toggleOut     (toggleOut)
	);

	source_model src_u
	(
		.clk_sys     (clk_sys),
		.edgeReq     (edgeReq),
		.slow        (slow),
		.countSource (countSource),
		.busy        (busy)
	);

	// Run is under a thousand cycles; ceiling leaves wide margin
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (terminalCount === 1'b1)
			tcTotal <= tcTotal + 1;
		if (cycles == 20000)
		begin
			err_total++;
			tally_and_finish();
		end
	end

	function automatic logic [CNT_W-1:0] pick(input logic [CNT_W-1:0] base);
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return base + {14'h0000, seed[1:0]};
	endfunction : pick

	// Count left after n edges of a repeating single-phase count
	function automatic logic [CNT_W-1:0] remain(input logic [CNT_W-1:0] l, input int n);
		return l - CNT_W'(n % int'(l));
	endfunction : remain

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask : tick

	task automatic edges(input int k);
		int w;
		repeat (k)
		begin
			edgeReq = 1'b1;
			tick(1);
			edgeReq = 1'b0;
			w = 0;
			while (busy === 1'b1 && w < 40)
			begin
				tick(1);
				w++;
			end
			tick(1);
		end
	endtask : edges

	task automatic setGate(input logic v);
		gateIn = v;
		tick(5);
	endtask : setGate

	task automatic start(input logic [2:0] g, input logic sp, input logic rl, input logic rp);
		hostCmd.disarm = 1'b1;
		tick(1);
		hostCmd.disarm = 1'b0;
		lv = pick(16'h0004);
		hv = pick(16'h0002);
		modeCfg = '{gatingControlField: g, specialGateBit: sp,
			reloadSourceBit: rl, repeatSelectBit: rp};
		loadReg = lv;
		holdRegIn = hv;
		holdRegWrite = 1'b1;
		tick(1);
		holdRegWrite = 1'b0;
		hostCmd.arm = 1'b1;
		tick(1);
		hostCmd.arm = 1'b0;
		tick(1);
		chk(armed, 1'b1);
		chk(count, lv);
		chk(toggleOut, 1'b0);
	endtask : start

	task automatic tally_and_finish;
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		tick(4);
		nrst = 1'b1;
		tick(1);
		start(GATE_LVL_HI, 1'b0, 1'b0, 1'b0);
		edges(2);
		chk(count, lv);
		setGate(1'b1);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b0);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b1);
		n = tcTotal;
		edges(int'(lv) - 1);
		chk(count, lv);
		chk(armed, 1'b0);
		chk(tcTotal - n, 1);
		edges(1);
		chk(count, lv);
		setGate(1'b0);
		// Slow source while gate wanders: gate must not matter
		slow = 1'b1;
		start(GATE_NONE, 1'b0, 1'b0, 1'b1);
		n = tcTotal;
		edges(2);
		setGate(1'b1);
		edges(int'(lv) - 1);
		chk(count, remain(lv, int'(lv) + 1));
		chk(tcTotal - n, 1);
		chk(armed, 1'b1);
		hostCmd.disarm = 1'b1;
		tick(1);
		hostCmd.disarm = 1'b0;
		tick(1);
		chk(armed, 1'b0);
		slow = 1'b0;
		setGate(1'b0);
		start(GATE_EDGE_RISE, 1'b0, 1'b0, 1'b0);
		edges(2);
		chk(count, lv);
		setGate(1'b1);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b0);
		setGate(1'b1);
		edges(1);
		chk(count, lv - 16'h0002);
		edges(int'(lv) - 2);
		chk(armed, 1'b0);
		setGate(1'b0);
		setGate(1'b1);
		edges(1);
		chk(count, lv);
		setGate(1'b0);
		start(GATE_EDGE_RISE, 1'b0, 1'b0, 1'b1);
		setGate(1'b1);
		edges(1);
		setGate(1'b0);
		setGate(1'b1);
		edges(1);
		chk(count, lv - 16'h0002);
		edges(int'(lv) - 2);
		chk(count, lv);
		chk(armed, 1'b1);
		edges(1);
		chk(count, lv);
		setGate(1'b0);
		setGate(1'b1);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b0);
		// Two-phase load/hold, once then repeating
		for (int rp = 0; rp < 2; rp++)
		begin
			start(GATE_NONE, 1'b0, 1'b1, rp[0]);
			edges(int'(lv));
			chk(count, hv);
			chk(toggleOut, 1'b1);
			edges(int'(hv));
			chk(toggleOut, 1'b0);
			chk(count, lv);
			chk(armed, rp[0]);
		end
		// Edge retrigger: reload waits for the next source edge
		start(GATE_EDGE_RISE, 1'b1, 1'b0, 1'b0);
		setGate(1'b1);
		edges(2);
		setGate(1'b0);
		edges(1);
		chk(count, lv - 16'h0003);
		setGate(1'b1);
		chk(holdReg, lv - 16'h0003);
		chk(count, lv - 16'h0003);
		edges(1);
		chk(count, lv);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b0);
		// Retriggerable one-shot: save and reload at once, level ignored
		start(GATE_EDGE_RISE, 1'b1, 1'b0, 1'b1);
		setGate(1'b1);
		edges(1);
		setGate(1'b0);
		setGate(1'b1);
		chk(holdReg, lv - 16'h0001);
		chk(count, lv);
		setGate(1'b0);
		edges(1);
		chk(count, lv - 16'h0001);
		// Level retrigger strobe: halt on gate low, save on return
		start(GATE_LVL_HI, 1'b1, 1'b0, 1'b0);
		edges(1);
		chk(count, lv);
		setGate(1'b1);
		edges(2);
		chk(count, lv - 16'h0001);
		setGate(1'b0);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b1);
		chk(holdReg, lv - 16'h0001);
		edges(1);
		chk(count, lv);
		setGate(1'b0);
		// Synchronised rate generator: count resumes on second edge
		start(GATE_LVL_HI, 1'b1, 1'b0, 1'b1);
		edges(1);
		chk(count, lv);
		setGate(1'b1);
		edges(1);
		chk(count, lv);
		edges(1);
		chk(count, lv - 16'h0001);
		setGate(1'b0);
		start(GATE_LVL_HI, 1'b0, 1'b0, 1'b1);
		edges(1);
		chk(count, lv);
		setGate(1'b1);
		edges(int'(lv) + 1);
		chk(count, remain(lv, int'(lv) + 1));
		chk(armed, 1'b1);
		tally_and_finish();
	end
endmodule : counter_mode_sequencer_tb
